/* verilog/acs_pkg.sv */
// Shared constants, field positions and types of the ADC startup sequencer.
package acs_pkg;

    // Clock rate of the system domain in MHz.
    localparam int CLK_MHZ = 100;

    // Chip-select noise filter: least setup time, rounded up to cycles.
    localparam int SETUP_NS  = 33;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;

    // Abort window after the last falling I/O clock edge, rounded down.
    localparam int ABORT_NS  = 1500;
    localparam int ABORT_CYC = (ABORT_NS * CLK_MHZ) / 1000;

    // Longest conversion time of the internal converter, rounded down.
    localparam int CONV_NS  = 1600;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;

    // Widths of counters and data words.
    localparam int CNT_W    = 8;
    localparam int SAMPLE_W = 12;
    localparam int WORD_W   = 16;
    localparam int CMD_W    = 8;
    localparam int BITS_W   = 5;

    // Command word layout: upper nibble command, lower nibble data.
    localparam int CMD_HI  = 7;
    localparam int CMD_LO  = 4;
    localparam int DATA_HI = 3;
    localparam int DATA_LO = 0;
    localparam logic [3:0] CMD_REF_STATUS = 4'hf;

    // Fields of both configuration nibbles.
    localparam int SEL_HI   = 3;
    localparam int SEL_LO   = 2;
    localparam int MID_BIT  = 1;
    localparam int LOW_BIT  = 0;

    // Reset values of the two configuration registers.
    localparam logic [3:0] REF_CFG_RST = 4'h0;
    localparam logic [3:0] FMT_CFG_RST = 4'h0;

    // Output length codes and the matching clock counts.
    localparam logic [1:0] LEN_CODE_8  = 2'h1;
    localparam logic [1:0] LEN_CODE_16 = 2'h3;
    localparam logic [BITS_W-1:0] LEN_8   = 5'h08;
    localparam logic [BITS_W-1:0] LEN_12  = 5'h0c;
    localparam logic [BITS_W-1:0] LEN_16  = 5'h10;
    localparam logic [BITS_W-1:0] CMD_LAST = 5'h07;

    // Transfer cycles counted from power up; saturates at the third.
    localparam logic [1:0] FRAMES_MAX = 2'h3;

    // Converter states.
    typedef enum logic [0:0] {
        CV_IDLE = 1'b0,
        CV_BUSY = 1'b1
    } acs_conv_t;

    // Clock count of a transfer for a given length code.
    function automatic logic [BITS_W-1:0] frame_len(input logic [1:0] code);
        logic [BITS_W-1:0] len;
        len = LEN_12;
        if (code == LEN_CODE_8) begin
            len = LEN_8;
        end else if (code == LEN_CODE_16) begin
            len = LEN_16;
        end
        return len;
    endfunction : frame_len

endpackage : acs_pkg

/* verilog/acs_sync3.sv */
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module acs_sync3 #(
    parameter int W = 1
) (
    // Clock and control.
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    // Asynchronous input and its filtered copy.
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    // One chain per bit; only the second and third stages are compared.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    q_reg[i]  <= 1'b0;
                end else if (ce) begin
                    s1_reg[i] <= d_async[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        q_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign q = q_reg;

endmodule : acs_sync3

/* verilog/acs_serial_link.sv */
// Serial link logic clocked by the host's I/O clock.
`timescale 1ns/1ps
module acs_serial_link (
    // Link clock, frame select and global reset.
    input  wire logic        io_clk,
    input  wire logic        cs_n,
    input  wire logic        rst,
    // Quasi-static controls from the system domain.
    input  wire logic        armed,
    input  wire logic [1:0]  len_code,
    input  wire logic [15:0] out_word,
    // Serial pins.
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_oe_n,
    // Events toward the system domain.
    output logic [7:0]       cmd_word,
    output logic             cmd_tgl,
    output logic             frame_tgl
);

    typedef struct packed {
        logic [acs_pkg::BITS_W-1:0] bit_cnt;
        logic [acs_pkg::CMD_W-1:0]  shreg;
    } acs_rise_t;

    acs_rise_t rise_reg;
    acs_rise_t rise_next;
    logic [acs_pkg::CMD_W-1:0]  cmd_reg;
    logic                       cmd_tgl_reg;
    logic [acs_pkg::BITS_W-1:0] fall_reg;
    logic                       frame_tgl_reg;
    logic [acs_pkg::BITS_W-1:0] len;

    assign len = acs_pkg::frame_len(len_code);

    // Rising edges shift in the eight command bits; later bits are ignored.
    // Edges before the filter arms are dropped (see RULE7).
    always_comb begin
        rise_next = rise_reg;
        if (armed) begin
            if (rise_reg.bit_cnt < acs_pkg::LEN_8) begin
                rise_next.shreg = {rise_reg.shreg[6:0], data_in}; // see RULE10
            end
            if (rise_reg.bit_cnt + 5'h01 >= len) begin
                rise_next.bit_cnt = '0; // see RULE5
            end else begin
                rise_next.bit_cnt = rise_reg.bit_cnt + 5'h01;
            end
        end
    end

    // Frame counters restart whenever chip select is high.
    always_ff @(posedge io_clk or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            rise_reg <= '0;
        end else begin
            rise_reg <= rise_next;
        end
    end

    // The command word is held until the next one is complete, so the
    // system domain can read it long after the toggle arrives.
    always_ff @(posedge io_clk or posedge rst) begin
        if (rst) begin
            cmd_reg     <= '0;
            cmd_tgl_reg <= 1'b0;
        end else if (armed && !cs_n &&
                     rise_reg.bit_cnt == acs_pkg::CMD_LAST) begin
            cmd_reg     <= {rise_reg.shreg[6:0], data_in}; // see RULE10
            cmd_tgl_reg <= ~cmd_tgl_reg;
        end
    end

    // Falling edges advance the output bit; the last one ends the frame.
    always_ff @(negedge io_clk or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            fall_reg <= '0;
        end else if (armed) begin
            if (fall_reg + 5'h01 >= len) begin
                fall_reg <= '0; // see RULE9
            end else begin
                fall_reg <= fall_reg + 5'h01;
            end
        end
    end

    // Frame-end event survives chip select so it is never falsely toggled.
    always_ff @(negedge io_clk or posedge rst) begin
        if (rst) begin
            frame_tgl_reg <= 1'b0;
        end else if (armed && !cs_n && fall_reg + 5'h01 >= len) begin
            frame_tgl_reg <= ~frame_tgl_reg; // see RULE9
        end
    end

    // The first bit shows as soon as chip select falls, before any clock.
    assign data_out      = out_word[4'hf - fall_reg[3:0]];
    assign data_out_oe_n = cs_n;
    assign cmd_word      = cmd_reg;
    assign cmd_tgl       = cmd_tgl_reg;
    assign frame_tgl     = frame_tgl_reg;

endmodule : acs_serial_link

/* verilog/acs_startup_seq.sv */
// Top of the ADC configuration and startup sequencer.
//
// Notes on behaviour
// RULE1: The host writes the reference and status register with command 1111 before expecting valid data.
// RULE2: The reference and status command is accepted in 8, 12 or 16 clock transfers.
// RULE3: The host gives at least eight clocks so the whole command byte loads.
// RULE4: The cycle after the reference and status command loads the format register and converts validly.
// RULE5: Chip select may stay low across all later transfers and operation continues.
// RULE6: The first valid result is shifted out during the third transfer from power up.
// RULE7: After chip select falls, clock and data are ignored for a filter setup time.
// RULE8: Chip select falling within 1.5 us after the last falling clock aborts the conversion.
// RULE9: A device cycle is the longest conversion time plus a transfer of 8, 12 or 16 clocks.
// RULE10: Each command is eight bits on the first eight rising clocks, command nibble then data nibble.
// RULE11: Under command 1111 the data nibble is reference select, status polarity and default mode.
// RULE12: Under other commands the data nibble is output length, bit order and bipolar select.
// RULE13: Clearing the default mode bit leaves default mode; valid cycles resume on the next cycle.
// RULE14: Results shifted out before the reference and status command are marked invalid.
// RULE15: The host counts three transfers after power up before it trusts returned data.
`timescale 1ns/1ps
module acs_startup_seq (
    // System clock, reset and enable.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // Serial link from the host.
    input  wire logic        io_clk,
    input  wire logic        cs_n,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_oe_n,
    // Converter core.
    input  wire logic [11:0] sample_code,
    output logic [3:0]       channel,
    output logic             converting,
    // Conversion status pin.
    output logic             conv_status,
    // Configuration state.
    output logic [1:0]       ref_select,
    output logic             status_int_mode,
    output logic             default_mode,
    output logic [1:0]       out_len_sel,
    output logic             lsb_first,
    output logic             bipolar,
    // Startup state.
    output logic             ref_cfg_done,
    output logic             result_valid,
    output logic [1:0]       frames_seen
);

    typedef struct packed {
        logic                       cs_prev;
        logic                       armed;
        logic [acs_pkg::CNT_W-1:0]  setup_cnt;
        logic                       cmd_seen;
        logic                       frame_seen;
        logic                       cmd_in_frame;
        logic                       conv_ok;
        logic [3:0]                 ref_cfg;
        logic [3:0]                 fmt_cfg;
        logic                       ref_done;
        logic [3:0]                 chan;
        acs_pkg::acs_conv_t         conv;
        logic [acs_pkg::CNT_W-1:0]  conv_cnt;
        logic [acs_pkg::CNT_W-1:0]  abort_cnt;
        logic                       run_ok;
        logic [acs_pkg::WORD_W-1:0] result;
        logic                       res_valid;
        logic                       done_pend;
        logic [1:0]                 frames;
        logic                       status;
    } acs_state_t;

    acs_state_t st_reg;
    acs_state_t st_next;

    logic        cs_s;
    logic        cs_sel;
    logic [1:0]  tgl_s;
    logic [7:0]  cmd_word;
    logic        cmd_tgl;
    logic        frame_tgl;
    logic        cs_fall;
    logic        cs_rise;
    logic        cmd_evt;
    logic        frame_evt;
    logic [acs_pkg::WORD_W-1:0] fmt_word;

    // Chip select and the two link events each cross on three flops.
    acs_sync3 #(
        .W (1)
    ) u_cs_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .d_async (~cs_n),
        .q       (cs_sel)
    );

    // Crossed inverted so reset leaves no false select edge.
    assign cs_s = ~cs_sel;

    acs_sync3 #(
        .W (2)
    ) u_evt_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .d_async ({frame_tgl, cmd_tgl}),
        .q       (tgl_s)
    );

    // The armed level and result word only change while the link clock
    // stands still, the length code right after the command byte, so the link reads them without a crossing.
    // The trade is that the host must honour the setup time and the
    // conversion time; the frame toggles tell us it did.
    acs_serial_link u_link (
        .io_clk        (io_clk),
        .cs_n          (cs_n),
        .rst           (rst),
        .armed         (st_reg.armed),
        .len_code      (st_reg.fmt_cfg[acs_pkg::SEL_HI:acs_pkg::SEL_LO]),
        .out_word      (st_reg.result),
        .data_in       (data_in),
        .data_out      (data_out),
        .data_out_oe_n (data_out_oe_n),
        .cmd_word      (cmd_word),
        .cmd_tgl       (cmd_tgl),
        .frame_tgl     (frame_tgl)
    );

    // Edges and events seen in the system domain.
    assign cs_fall   = st_reg.cs_prev && !cs_s;
    assign cs_rise   = !st_reg.cs_prev && cs_s;
    assign cmd_evt   = tgl_s[0] != st_reg.cmd_seen;
    // A frame ends on its last falling clock, or on chip select rising
    // once the command byte is in, which covers any accepted length.
    assign frame_evt = ((tgl_s[1] != st_reg.frame_seen) || cs_rise)
                       && st_reg.cmd_in_frame; // see RULE2

    // Result word laid out MSB first in the top bits, in the chosen order
    // and coding, so the link only ever shifts from the top down.
    always_comb begin
        logic [acs_pkg::SAMPLE_W-1:0] s;
        logic [acs_pkg::SAMPLE_W-1:0] r;
        s = sample_code;
        r = '0;
        if (st_reg.fmt_cfg[acs_pkg::LOW_BIT]) begin
            s = {~sample_code[11], sample_code[10:0]}; // see RULE12
        end
        for (int i = 0; i < acs_pkg::SAMPLE_W; i++) begin
            r[i] = s[acs_pkg::SAMPLE_W-1-i];
        end
        if (!st_reg.fmt_cfg[acs_pkg::MID_BIT]) begin
            r = s;
        end
        fmt_word = {r, 4'h0};
    end

    // Next-state logic of the whole sequencer.
    always_comb begin
        st_next = st_reg;
        st_next.cs_prev = cs_s;

        // Chip select filter: arm only after the setup time has passed.
        if (cs_s) begin
            st_next.armed     = 1'b0;
            st_next.setup_cnt = '0;
        end else if (!st_reg.armed) begin
            if (st_reg.setup_cnt + 8'h01 >= 8'(acs_pkg::SETUP_CYC)) begin
                st_next.armed = 1'b1; // see RULE7
            end else begin
                st_next.setup_cnt = st_reg.setup_cnt + 8'h01;
            end
        end

        // Cleared when a new transfer begins; a result finishing in the
        // same cycle still sets it below.
        if (cs_fall || cmd_evt) begin
            st_next.done_pend = 1'b0;
        end

        // Command decode once the eighth bit has crossed.
        if (cmd_evt) begin
            st_next.cmd_seen     = tgl_s[0];
            st_next.cmd_in_frame = 1'b1;
            if (cmd_word[acs_pkg::CMD_HI:acs_pkg::CMD_LO]
                == acs_pkg::CMD_REF_STATUS) begin
                st_next.ref_cfg  = cmd_word[acs_pkg::DATA_HI:acs_pkg::DATA_LO];
                st_next.ref_done = 1'b1; // see RULE11
                st_next.conv_ok  = 1'b0;
            end else begin
                st_next.fmt_cfg = cmd_word[acs_pkg::DATA_HI:acs_pkg::DATA_LO];
                st_next.chan    = cmd_word[acs_pkg::CMD_HI:acs_pkg::CMD_LO];
                // Valid only once the reference command has been taken;
                // a default-mode exit counts from this very cycle.
                st_next.conv_ok = st_reg.ref_done; // see RULE4
            end
        end

        // Frame end: start the conversion of the addressed input.
        if (tgl_s[1] != st_reg.frame_seen) begin
            st_next.frame_seen = tgl_s[1];
        end
        if (frame_evt) begin
            st_next.cmd_in_frame = 1'b0;
            if (st_reg.frames != acs_pkg::FRAMES_MAX) begin
                st_next.frames = st_reg.frames + 2'h1; // see RULE6
            end
            st_next.conv      = acs_pkg::CV_BUSY; // see RULE9
            st_next.conv_cnt  = '0;
            st_next.abort_cnt = '0;
            st_next.run_ok    = st_reg.conv_ok;
        end else begin
            case (st_reg.conv)
                acs_pkg::CV_IDLE: begin
                    st_next.conv_cnt = '0;
                end
                acs_pkg::CV_BUSY: begin
                    if (st_reg.abort_cnt < 8'(acs_pkg::ABORT_CYC)) begin
                        st_next.abort_cnt = st_reg.abort_cnt + 8'h01;
                    end
                    if (cs_fall &&
                        st_reg.abort_cnt < 8'(acs_pkg::ABORT_CYC)) begin
                        st_next.conv = acs_pkg::CV_IDLE; // see RULE8
                    end else if (st_reg.conv_cnt + 8'h01
                                 >= 8'(acs_pkg::CONV_CYC)) begin
                        st_next.conv      = acs_pkg::CV_IDLE; // see RULE9
                        st_next.done_pend = 1'b1;
                        // Invalid results shift out as zeros.
                        st_next.result    = st_reg.run_ok ? fmt_word : '0;
                        st_next.res_valid = st_reg.run_ok; // see RULE14
                    end else begin
                        st_next.conv_cnt = st_reg.conv_cnt + 8'h01;
                    end
                end
                default: begin
                    st_next.conv = acs_pkg::CV_IDLE;
                end
            endcase
        end

        // Status pin: end-of-conversion level, or interrupt pulled low
        // while a finished result waits for the host.
        if (st_reg.ref_cfg[acs_pkg::MID_BIT]) begin
            st_next.status = !st_next.done_pend; // see RULE11
        end else begin
            st_next.status = st_next.conv != acs_pkg::CV_BUSY;
        end
    end

    // All state registers; reset brings the converter to a clean idle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.cs_prev <= 1'b1;
            st_reg.ref_cfg <= acs_pkg::REF_CFG_RST;
            st_reg.fmt_cfg <= acs_pkg::FMT_CFG_RST;
            st_reg.conv    <= acs_pkg::CV_IDLE;
            st_reg.status  <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign channel         = st_reg.chan;
    assign converting      = st_reg.conv == acs_pkg::CV_BUSY;
    assign conv_status     = st_reg.status;
    assign ref_select      = st_reg.ref_cfg[acs_pkg::SEL_HI:acs_pkg::SEL_LO];
    assign status_int_mode = st_reg.ref_cfg[acs_pkg::MID_BIT];
    assign default_mode    = st_reg.ref_cfg[acs_pkg::LOW_BIT]; // see RULE13
    assign out_len_sel     = st_reg.fmt_cfg[acs_pkg::SEL_HI:acs_pkg::SEL_LO];
    assign lsb_first       = st_reg.fmt_cfg[acs_pkg::MID_BIT];
    assign bipolar         = st_reg.fmt_cfg[acs_pkg::LOW_BIT];
    assign ref_cfg_done    = st_reg.ref_done;
    assign result_valid    = st_reg.res_valid;
    assign frames_seen     = st_reg.frames;

endmodule : acs_startup_seq

/* sim/acs_monitor.sv */
// Port checks of the ADC startup sequencer.
`timescale 1ns/1ps
module acs_monitor (
    // Clock, reset and enable.
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       ce,
    // Link and status pins.
    input wire logic       cs_n,
    input wire logic       data_out_oe_n,
    input wire logic       converting,
    input wire logic       conv_status,
    // Configuration and startup state.
    input wire logic [1:0] ref_select,
    input wire logic       status_int_mode,
    input wire logic       ref_cfg_done,
    input wire logic       result_valid,
    input wire logic [1:0] frames_seen
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Busy length; a converter that never ends would starve the host.
    logic [8:0] busy_reg;
    always_ff @(posedge clk_sys) begin
        if (rst || !converting) begin
            busy_reg <= 9'h000;
        end else if (ce) begin
            busy_reg <= busy_reg + 9'h001;
        end
    end

    // Two busy cycles in a row.
    sequence s_busy2;
        converting [*2];
    endsequence

    a_busy_bounded: assert property (busy_reg <= 9'h0a1)
        else $error("conversion ran too long");
    a_valid_after_cfg: assert property (result_valid |-> ref_cfg_done)
        else $error("result valid before reference setup");
    a_frames_monotone: assert property (frames_seen != 2'h0
        |=> frames_seen >= $past(frames_seen))
        else $error("frame count went back");
    a_oe_follows_cs: assert property (data_out_oe_n == cs_n)
        else $error("output enable differs from select");
    a_eoc_idle: assert property (!status_int_mode && !$past(status_int_mode)
        && !converting && !$past(converting) |-> conv_status)
        else $error("status low while idle");
    a_eoc_busy: assert property (s_busy2 ##0 (!status_int_mode
        && !$past(status_int_mode)) |-> !conv_status)
        else $error("status high while busy");
    a_ref_needs_cmd: assert property ($changed(ref_select) |-> ref_cfg_done)
        else $error("reference changed without command");
    a_valid_at_end: assert property ($rose(result_valid) |->
        $past(converting) || $past(converting, 2))
        else $error("result valid away from conversion end");
endmodule : acs_monitor

bind acs_startup_seq acs_monitor u_acs_monitor (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .cs_n(cs_n),
    .data_out_oe_n(data_out_oe_n), .converting(converting),
    .conv_status(conv_status), .ref_select(ref_select),
    .status_int_mode(status_int_mode), .ref_cfg_done(ref_cfg_done),
    .result_valid(result_valid), .frames_seen(frames_seen)
);

/* sim/acs_host_model.sv */
// Host serial port model driving the sequencer's link.
`timescale 1ns/1ps
module acs_host_model (
    // Host driven link lines.
    output logic      io_clk,
    output logic      cs_n,
    output logic      data_in,
    // Device answer.
    input wire logic  data_out,
    input wire logic  data_out_oe_n
);
    logic [15:0] rx_word;

    // The link clock stands low outside frames.
    initial begin
        io_clk  = 1'b0;
        cs_n    = 1'b1;
        data_in = 1'b0;
        rx_word = 16'h0000;
    end

    // One transfer of nclk clocks at a 64 ns period.
    task automatic xfer(input logic [7:0] cmd, input int nclk, input bit keep);
        int i;
        #3;
        if (cs_n) begin
            cs_n = 1'b0;
            #200; // Waits out the select filter.
        end else begin
            #20;
        end
        rx_word = 16'h0000;
        for (i = 0; i < nclk; i++) begin
            data_in = (i < 8) ? cmd[7-i] : ~data_in;
            #16;
            io_clk = 1'b1;
            rx_word[15-i] = data_out;
            #32;
            io_clk = 1'b0;
            #16;
        end
        // Released data line shows the inverse, not a held value.
        data_in = ~data_in;
        if (!keep) begin
            #100;
            cs_n = 1'b1;
            #100;
        end
    endtask : xfer
endmodule : acs_host_model

/* sim/testbench.sv */
// Self-checking bench of the ADC startup sequencer.
`timescale 1ns/1ps
module testbench;
    logic        clk_sys;
    logic        rst;
    logic [11:0] sample_code;
    logic        io_clk, cs_n, data_in, data_out, data_out_oe_n;
    logic [3:0]  channel;
    logic        converting, conv_status, status_int_mode, default_mode;
    logic [1:0]  ref_select, out_len_sel, frames_seen;
    logic        lsb_first, bipolar, ref_cfg_done, result_valid;
    int          n_fail = 0;
    int          samples_checked = 0;

    acs_startup_seq u_acs_startup_seq (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .io_clk(io_clk),
        .cs_n(cs_n), .data_in(data_in), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n), .sample_code(sample_code),
        .channel(channel), .converting(converting),
        .conv_status(conv_status), .ref_select(ref_select),
        .status_int_mode(status_int_mode), .default_mode(default_mode),
        .out_len_sel(out_len_sel), .lsb_first(lsb_first),
        .bipolar(bipolar), .ref_cfg_done(ref_cfg_done),
        .result_valid(result_valid), .frames_seen(frames_seen)
    );
    acs_host_model u_acs_host_model (
        .io_clk(io_clk), .cs_n(cs_n), .data_in(data_in),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n)
    );

    // System clock, 10 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic set_code(input logic [11:0] v);
        @(posedge clk_sys);
        #1 sample_code = v;
    endtask : set_code

    // Waits out one conversion; entry may lag its start a little.
    task automatic wait_conv();
        int n;
        n = 0;
        while (!converting && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (converting && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk("busy_len", 16'(n >= 120 && n <= 161), 16'h0001);
        repeat (4) @(posedge clk_sys);
    endtask : wait_conv

    // Reference setup, then format, then the first valid word.
    task automatic t_startup();
        chk("cfg_done0", ref_cfg_done, 16'h0000);
        chk("valid0", result_valid, 16'h0000);
        set_code(12'ha53);
        u_acs_host_model.xfer(8'hf8, 8, 1'b0);
        wait_conv();
        chk("ref_sel", ref_select, 16'h0002);
        chk("cfg_done", ref_cfg_done, 16'h0001);
        chk("word1", u_acs_host_model.rx_word, 16'h0000);
        u_acs_host_model.xfer(8'h3c, 12, 1'b0);
        wait_conv();
        chk("channel", channel, 16'h0003);
        chk("len_sel", out_len_sel, 16'h0003);
        chk("valid2", result_valid, 16'h0001);
        set_code(12'h5c3);
        // Data is trusted only from the third transfer on.
        u_acs_host_model.xfer(8'h3f, 16, 1'b0);
        wait_conv();
        chk("word3", u_acs_host_model.rx_word, 16'ha530);
        chk("frames", frames_seen, 16'h0003);
        chk("lsb", lsb_first, 16'h0001);
        chk("bip", bipolar, 16'h0001);
        $display("startup test done");
    endtask : t_startup

    // Reversed bipolar word, then frames with select held low.
    task automatic t_format();
        u_acs_host_model.xfer(8'h3c, 16, 1'b0);
        wait_conv();
        chk("word_lsb", u_acs_host_model.rx_word, 16'hc3b0);
        u_acs_host_model.xfer(8'hff, 16, 1'b1);
        wait_conv();
        chk("int_mode", status_int_mode, 16'h0001);
        chk("dflt", default_mode, 16'h0001);
        u_acs_host_model.xfer(8'h3c, 16, 1'b1);
        wait_conv();
        chk("int_low", conv_status, 16'h0000);
        u_acs_host_model.xfer(8'hf0, 16, 1'b0);
        wait_conv();
        chk("dflt_off", default_mode, 16'h0000);
        chk("valid_cfg", result_valid, 16'h0000);
        chk("frames_sat", frames_seen, 16'h0003);
        $display("format test done");
    endtask : t_format

    // Select falls during a conversion; the held word is kept.
    task automatic t_abort();
        u_acs_host_model.xfer(8'h3c, 16, 1'b0);
        wait_conv();
        chk("valid_on", result_valid, 16'h0001);
        u_acs_host_model.xfer(8'h3c, 16, 1'b0);
        set_code(12'h777);
        fork
            u_acs_host_model.xfer(8'h3c, 16, 1'b0);
            begin
                #250;
                chk("abort", converting, 16'h0000);
            end
        join
        chk("word_kept", u_acs_host_model.rx_word, 16'h5c30);
        wait_conv();
        $display("abort test done");
    endtask : t_abort

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Cuts a hang short after well over the expected run time.
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        sample_code = 12'h000;
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk_sys);
        t_startup();
        t_format();
        t_abort();
        report_and_stop();
    end
endmodule : testbench
